// ### core/tcs_map.vh
// constants for the tape controller command and status block
// Summary of operation
// - codes 5, 6, 7 write record, write file mark, write erase gap
// - codes 8-12 read, forward/back space record, forward/back space file
// - code 13 rewind, 14 rewind and off-line, 15 read record backward
// - end byte bit 3 clears jump code of selected unit only
// - end byte bit 5 enables parallel-poll response for all units
// - end byte bit 6 stops polling of selected unit only, inhibits its poll response in read bursts
// - end byte bit 7 clears selected unit service request; bits 0,1,2,4 reserved
// - status 1 bits 0-3: file mark, load point, tape end, single-track error
// - status 1 bits 4-7: rejected, file protected, multi-track error, on-line
// - status 2 bits 1-2 hold selected unit, bit 1 msb; bit 0 reserved
// - status 2 bits 3-7: timing error, runaway, rewinding, unit busy, iface busy
// - status 3 bit 2 set when power restored; bits 0,1,3 reserved
// - status 3 bits 4-7 flag unit 3,2,1,0 just placed on-line
// - jump code zero after good transfer, 1 after failed transfer, 2 after rejected command
// - status bit 0 on data line 8, bit 7 on data line 1
`ifndef TCS_MAP_VH
`define TCS_MAP_VH

`define TCS_OP_RSVD     4'h0
`define TCS_OP_SEL0     4'h1
`define TCS_OP_SEL3     4'h4
`define TCS_OP_WREC     4'h5
`define TCS_OP_WFM      4'h6
`define TCS_OP_WGAP     4'h7
`define TCS_OP_RREC     4'h8
`define TCS_OP_FSR      4'h9
`define TCS_OP_BSR      4'ha
`define TCS_OP_FSF      4'hb
`define TCS_OP_BSF      4'hc
`define TCS_OP_REW      4'hd
`define TCS_OP_REWOFF   4'he
`define TCS_OP_RBACK    4'hf

`define TCS_END_CLR_JUMP 3
`define TCS_END_PP_EN    5
`define TCS_END_POLL_OFF 6
`define TCS_END_SRQ_CLR  7

`define TCS_S1_FM        0
`define TCS_S1_LOADPT    1
`define TCS_S1_TAPEEND   2
`define TCS_S1_STE       3
`define TCS_S1_REJECT    4
`define TCS_S1_PROTECT   5
`define TCS_S1_MTE       6
`define TCS_S1_ONLINE    7

`define TCS_S2_UNIT_MSB  1
`define TCS_S2_UNIT_LSB  2
`define TCS_S2_TIMING    3
`define TCS_S2_RUNAWAY   4
`define TCS_S2_REWIND    5
`define TCS_S2_UBUSY     6
`define TCS_S2_IBUSY     7

`define TCS_S3_POWER     2
`define TCS_S3_ONL_U3    4

`define TCS_SEL_JUMP     2'h0
`define TCS_SEL_STAT1    2'h1
`define TCS_SEL_STAT2    2'h2
`define TCS_SEL_STAT3    2'h3

`define TCS_JUMP_OK      2'h0
`define TCS_JUMP_FAIL    2'h1
`define TCS_JUMP_REJECT  2'h2

`endif

// ### core/tcs_unit.v
// per-unit jump code, service request and poll control
`timescale 1ns/1ps
`include "tcs_map.vh"
module tcs_unit (
  input  wire       core_clk,
  input  wire       arst_n,
  input  wire       sel,
  input  wire       jump_load,
  input  wire [1:0] jump_val,
  input  wire       jump_clr,
  input  wire       srq_set,
  input  wire       srq_clr,
  input  wire       pp_en_all,
  input  wire       poll_off,
  input  wire       read_burst,
  input  wire       online,
  input  wire       onl_clr,
  output reg  [1:0] jump_q,
  output reg        pp_resp_q,
  output reg        poll_off_q,
  output reg        onl_flag_q
);
  reg srq_q;
  reg pp_en_q;
  reg online_q;
  // a unit already on-line as reset ends is no fresh event
  reg armed_q;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      jump_q     <= 2'h0;
      srq_q      <= 1'b0;
      pp_en_q    <= 1'b0;
      poll_off_q <= 1'b0;
      pp_resp_q  <= 1'b0;
      online_q   <= 1'b0;
      armed_q    <= 1'b0;
      onl_flag_q <= 1'b0;
    end else begin
      // a fresh result outranks a clear in the same cycle
      if (sel && jump_load)
        jump_q <= jump_val;
      else if (sel && jump_clr)
        jump_q <= `TCS_JUMP_OK;
      if (srq_set)
        srq_q <= 1'b1;
      else if (sel && srq_clr)
        srq_q <= 1'b0;
      if (pp_en_all)
        pp_en_q <= 1'b1;
      if (sel && poll_off)
        poll_off_q <= 1'b1;
      pp_resp_q <= srq_q && pp_en_q && !(poll_off_q && read_burst);
      online_q <= online;
      armed_q  <= 1'b1;
      if (online && !online_q && armed_q)
        onl_flag_q <= 1'b1;
      else if (onl_clr)
        onl_flag_q <= 1'b0;
    end
  end
endmodule

// ### core/tcs_ctrl.v
// command decode, end-command handling and status bytes of the tape controller
`timescale 1ns/1ps
`include "tcs_map.vh"
module tcs_ctrl #(
  parameter NUNITS = 4
) (
  input  wire              core_clk,
  input  wire              arst_n,
  input  wire              cmd_wr,
  input  wire              end_wr,
  input  wire              stat_rd,
  input  wire [1:0]        stat_sel,
  input  wire [7:0]        dio_i,
  input  wire [NUNITS-1:0] drv_online,
  input  wire [NUNITS-1:0] drv_load_point,
  input  wire [NUNITS-1:0] drv_tape_end,
  input  wire [NUNITS-1:0] drv_protect,
  input  wire [NUNITS-1:0] drv_busy,
  input  wire [NUNITS-1:0] drv_rewinding,
  input  wire              mot_done,
  input  wire              xfer_ok,
  input  wire              file_mark,
  input  wire              single_track_error,
  input  wire              multi_track_error,
  input  wire              timing_err,
  input  wire              runaway,
  input  wire              power_restored,
  input  wire              read_burst,
  output reg  [7:0]        dio_o,
  output reg               dio_oe,
  output reg               mot_go,
  output reg  [3:0]        mot_op,
  output reg  [1:0]        mot_unit,
  output reg               offline_req,
  output reg  [NUNITS-1:0] pp_resp,
  output reg  [NUNITS-1:0] poll_off
);
  localparam ST_IDLE = 3'b001;
  localparam ST_BUSY = 3'b010;
  localparam ST_DONE = 3'b100;

  reg  [2:0] state_q;
  reg  [2:0] state_d;
  reg  [1:0] unit_q;
  reg  [1:0] unit_d;
  reg        reject_q;
  reg        fm_q;
  reg        ste_q;
  reg        mte_q;
  reg        timing_q;
  reg        runaway_q;
  reg        power_q;
  reg  [7:0] stat_d;
  reg  [3:0] cmd_code;
  reg  [7:0] end_byte;
  reg        is_write;
  reg        is_motion;
  reg        rej_now;
  reg  [NUNITS-1:0] unit_sel;
  reg  [1:0] jump_sel;
  reg  [3:0] onl_bits;
  reg        jump_load;
  reg  [1:0] jump_val;
  wire [1:0] jump_w [0:NUNITS-1];
  wire [NUNITS-1:0] pp_w;
  wire [NUNITS-1:0] poll_w;
  wire [NUNITS-1:0] onl_w;
  wire       onl_clr;
  integer    i;

  // data lines are numbered opposite to byte bits
  function [7:0] line_order;
    input [7:0] b;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1)
        line_order[7-k] = b[k];
    end
  endfunction

  always @* begin
    end_byte = line_order(dio_i);
    cmd_code = end_byte[3:0];
    unit_sel = {NUNITS{1'b0}};
    unit_sel[unit_q] = 1'b1;
  end

  // command class decode
  always @* begin
    is_write  = 1'b0;
    is_motion = 1'b0;
    case (cmd_code)
      `TCS_OP_WREC, `TCS_OP_WFM, `TCS_OP_WGAP: begin
        is_write  = 1'b1;
        is_motion = 1'b1;
      end
      `TCS_OP_RREC, `TCS_OP_FSR, `TCS_OP_BSR, `TCS_OP_FSF, `TCS_OP_BSF: begin
        is_motion = 1'b1;
      end
      `TCS_OP_REW, `TCS_OP_REWOFF, `TCS_OP_RBACK: begin
        is_motion = 1'b1;
      end
      default: begin
        is_motion = 1'b0;
      end
    endcase
    // writes need a ring; motion needs an on-line unit and an idle interface
    rej_now = (cmd_code == `TCS_OP_RSVD)
           || (is_motion && !drv_online[unit_q])
           || (is_write && drv_protect[unit_q])
           || (is_motion && state_q != ST_IDLE);
  end

  // unit selection from the select codes
  always @* begin
    unit_d = unit_q;
    if (cmd_wr && cmd_code >= `TCS_OP_SEL0 && cmd_code <= `TCS_OP_SEL3)
      unit_d = cmd_code[1:0] - 2'h1;
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cmd_wr && is_motion && !rej_now)
          state_d = ST_BUSY;
      end
      ST_BUSY: begin
        if (mot_done)
          state_d = ST_DONE;
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // result of a finished transfer goes to the unit's jump code
  always @* begin
    jump_load = 1'b0;
    jump_val  = `TCS_JUMP_OK;
    if (cmd_wr && rej_now) begin
      jump_load = 1'b1;
      jump_val  = `TCS_JUMP_REJECT;
    end else if (state_q == ST_BUSY && mot_done) begin
      jump_load = 1'b1;
      jump_val  = xfer_ok ? `TCS_JUMP_OK : `TCS_JUMP_FAIL;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUNITS; g = g + 1) begin : g_unit
      tcs_unit u_unit (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .sel        (unit_sel[g]),
        .jump_load  (jump_load),
        .jump_val   (jump_val),
        .jump_clr   (end_wr && end_byte[`TCS_END_CLR_JUMP]),
        .srq_set    (state_q == ST_BUSY && mot_done && unit_sel[g]),
        .srq_clr    (end_wr && end_byte[`TCS_END_SRQ_CLR]),
        .pp_en_all  (end_wr && end_byte[`TCS_END_PP_EN]),
        .poll_off   (end_wr && end_byte[`TCS_END_POLL_OFF]),
        .read_burst (read_burst),
        .online     (drv_online[g]),
        .onl_clr    (onl_clr),
        .jump_q     (jump_w[g]),
        .pp_resp_q  (pp_w[g]),
        .poll_off_q (poll_w[g]),
        .onl_flag_q (onl_w[g])
      );
    end
  endgenerate

  // reading status byte 3 consumes its event flags
  assign onl_clr = stat_rd && (stat_sel == `TCS_SEL_STAT3);

  always @* begin
    jump_sel = jump_w[unit_q];
    onl_bits = 4'h0;
    for (i = 0; i < NUNITS && i < 4; i = i + 1)
      onl_bits[3-i] = onl_w[i];
  end

  // status byte assembly, in byte bit order
  always @* begin
    stat_d = 8'h00;
    case (stat_sel)
      `TCS_SEL_STAT1: begin
        stat_d[`TCS_S1_FM]      = fm_q;
        stat_d[`TCS_S1_LOADPT]  = drv_load_point[unit_q];
        stat_d[`TCS_S1_TAPEEND] = drv_tape_end[unit_q];
        stat_d[`TCS_S1_STE]     = ste_q;
        stat_d[`TCS_S1_REJECT]  = reject_q;
        stat_d[`TCS_S1_PROTECT] = drv_protect[unit_q];
        stat_d[`TCS_S1_MTE]     = mte_q;
        stat_d[`TCS_S1_ONLINE]  = drv_online[unit_q];
      end
      `TCS_SEL_STAT2: begin
        stat_d[`TCS_S2_UNIT_MSB] = unit_q[1];
        stat_d[`TCS_S2_UNIT_LSB] = unit_q[0];
        stat_d[`TCS_S2_TIMING]   = timing_q;
        stat_d[`TCS_S2_RUNAWAY]  = runaway_q;
        stat_d[`TCS_S2_REWIND]   = drv_rewinding[unit_q];
        stat_d[`TCS_S2_UBUSY]    = drv_busy[unit_q];
        stat_d[`TCS_S2_IBUSY]    = (state_q != ST_IDLE);
      end
      `TCS_SEL_STAT3: begin
        stat_d[`TCS_S3_POWER] = power_q;
        stat_d[7:`TCS_S3_ONL_U3] = onl_bits;
      end
      default: begin
        stat_d = {6'h00, jump_sel};
      end
    endcase
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q   <= ST_IDLE;
      unit_q    <= 2'h0;
      reject_q  <= 1'b0;
      fm_q      <= 1'b0;
      ste_q     <= 1'b0;
      mte_q     <= 1'b0;
      timing_q  <= 1'b0;
      runaway_q <= 1'b0;
      power_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      unit_q  <= unit_d;
      if (cmd_wr) begin
        reject_q <= rej_now;
      end
      // error flags restart with each accepted motion; a timing or runaway event in the
      // same cycle still wins; file mark and track errors count only while busy
      if (state_q == ST_BUSY && file_mark)
        fm_q <= 1'b1;
      else if (cmd_wr && is_motion && !rej_now)
        fm_q <= 1'b0;
      if (state_q == ST_BUSY && single_track_error)
        ste_q <= 1'b1;
      else if (cmd_wr && is_motion && !rej_now)
        ste_q <= 1'b0;
      if (state_q == ST_BUSY && multi_track_error)
        mte_q <= 1'b1;
      else if (cmd_wr && is_motion && !rej_now)
        mte_q <= 1'b0;
      if (timing_err)
        timing_q <= 1'b1;
      else if (cmd_wr && is_motion && !rej_now)
        timing_q <= 1'b0;
      if (runaway)
        runaway_q <= 1'b1;
      else if (cmd_wr && is_motion && !rej_now)
        runaway_q <= 1'b0;
      if (power_restored)
        power_q <= 1'b1;
      else if (onl_clr)
        power_q <= 1'b0;
    end
  end

  // registered outputs toward drives and bus
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dio_o       <= 8'h00;
      dio_oe      <= 1'b0;
      mot_go      <= 1'b0;
      mot_op      <= `TCS_OP_RSVD;
      mot_unit    <= 2'h0;
      offline_req <= 1'b0;
      pp_resp     <= {NUNITS{1'b0}};
      poll_off    <= {NUNITS{1'b0}};
    end else begin
      // one-cycle answer; host samples lines the cycle after its read
      dio_oe <= stat_rd;
      if (stat_rd)
        dio_o <= line_order(stat_d);
      mot_go <= cmd_wr && is_motion && !rej_now;
      if (cmd_wr && is_motion && !rej_now) begin
        mot_op   <= cmd_code;
        mot_unit <= unit_q;
      end
      offline_req <= cmd_wr && !rej_now && (cmd_code == `TCS_OP_REWOFF);
      pp_resp  <= pp_w;
      poll_off <= poll_w;
    end
  end
endmodule

// ### verification/tcs_ctrl_sva.sv
// assertions on the command and status ports of tcs_ctrl
`timescale 1ns/1ps
module tcs_ctrl_sva #(
  parameter NUNITS = 4
) (
  input wire              core_clk,
  input wire              arst_n,
  input wire              cmd_wr,
  input wire              end_wr,
  input wire              stat_rd,
  input wire [1:0]        stat_sel,
  input wire [7:0]        dio_i,
  input wire              power_restored,
  input wire [7:0]        dio_o,
  input wire              dio_oe,
  input wire              mot_go,
  input wire [3:0]        mot_op,
  input wire              offline_req,
  input wire [NUNITS-1:0] pp_resp,
  input wire [NUNITS-1:0] poll_off
);
  // code bit 0 arrives on line 8
  wire [3:0] code = {dio_i[4], dio_i[5], dio_i[6], dio_i[7]};
  reg        pp_seen_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pp_seen_q <= 1'b0;
    end else if (end_wr && dio_i[2]) begin
      pp_seen_q <= 1'b1;
    end
  end

  sequence s_reject_read;
    cmd_wr && code == 4'h0 ##2 stat_rd && stat_sel == 2'h1;
  endsequence
  sequence s_power_read;
    power_restored ##2 stat_rd && stat_sel == 2'h3;
  endsequence

  a_read_answer: assert property (stat_rd |=> dio_oe)
    else $error("read not answered");
  a_oe_cause: assert property (dio_oe |-> $past(stat_rd))
    else $error("drive without read");
  a_rsvd_code: assert property (cmd_wr && code == 4'h0 |=> !mot_go)
    else $error("reserved code started motion");
  a_select_nogo: assert property (cmd_wr && code inside {[1:4]} |=> !mot_go)
    else $error("select started motion");
  a_go_code: assert property (mot_go |-> $past(cmd_wr) && mot_op == $past(code)
    && mot_op > 4'h4)
    else $error("motion op wrong");
  a_offline_op: assert property (offline_req |-> mot_go && mot_op == 4'he)
    else $error("off-line request without code 14");
  a_reject_flag: assert property (s_reject_read |=> dio_o[3])
    else $error("reject flag missing");
  a_power_flag: assert property (s_power_read |=> dio_o[5])
    else $error("power flag missing");
  a_pp_enable: assert property (pp_resp != '0 |-> pp_seen_q)
    else $error("poll response before enable");
  a_poll_stop: assert property (end_wr && dio_i[1] |-> ##[1:2] poll_off != '0)
    else $error("polling not stopped");
endmodule

// ### verification/tcs_drive_model.sv
// drive-side model: answers each motion with a done pulse after a delay
`timescale 1ns/1ps
module tcs_drive_model #(
  parameter DELAY = 3
) (
  input  wire core_clk,
  input  wire arst_n,
  input  wire mot_go,
  input  wire ok,
  output reg  mot_done,
  output wire xfer_ok
);
  integer cnt;
  // inverted outside the pulse so a stale level is never read by luck
  assign xfer_ok = mot_done ? ok : ~ok;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      mot_done <= 1'b0;
    end else begin
      mot_done <= (cnt == 1);
      if (mot_go) begin
        cnt <= DELAY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// ### verification/testbench.sv
// self-checking bench for the tape controller command and status block
`timescale 1ns/1ps
module testbench;
  reg        core_clk, arst_n, cmd_wr, end_wr, stat_rd, ok, pwr, terr, rb, run;
  reg  [1:0] stat_sel, u;
  reg  [7:0] dio_i, v;
  reg  [3:0] onl, ldp, tend, prot, rew, busy;
  wire [7:0] dio_o;
  wire [3:0] mot_op, pp_resp, poll_off;
  wire [1:0] mot_unit;
  wire       dio_oe, mot_go, offline_req, mot_done, xfer_ok;
  integer    mismatches, checks_done, cyc, i;

  tcs_ctrl #(.NUNITS(4)) tcs_ctrl_inst (
    .core_clk(core_clk), .arst_n(arst_n), .cmd_wr(cmd_wr), .end_wr(end_wr),
    .stat_rd(stat_rd), .stat_sel(stat_sel), .dio_i(dio_i), .drv_online(onl),
    .drv_load_point(ldp), .drv_tape_end(tend), .drv_protect(prot), .drv_busy(busy),
    .drv_rewinding(rew), .mot_done(mot_done), .xfer_ok(xfer_ok), .file_mark(1'b0),
    .single_track_error(1'b0), .multi_track_error(1'b0), .timing_err(terr),
    .runaway(run), .power_restored(pwr), .read_burst(rb), .dio_o(dio_o),
    .dio_oe(dio_oe), .mot_go(mot_go), .mot_op(mot_op), .mot_unit(mot_unit),
    .offline_req(offline_req), .pp_resp(pp_resp), .poll_off(poll_off));
  tcs_drive_model #(.DELAY(3)) tcs_drive_model_inst (.core_clk(core_clk),
    .arst_n(arst_n), .mot_go(mot_go), .ok(ok), .mot_done(mot_done), .xfer_ok(xfer_ok));

  function [7:0] rev8(input [7:0] b);
    integer k;
    for (k = 0; k < 8; k = k + 1) rev8[k] = b[7-k];
  endfunction

  task chk(input [7:0] g, input [7:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("BAD %0t got %h want %h", $time, g, e);
      end
    end
  endtask

  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask

  task rd(input [1:0] s);
    begin
      @(posedge core_clk);
      stat_rd <= 1'b1;
      stat_sel <= s;
      @(posedge core_clk);
      stat_rd <= 1'b0;
      #1 v = rev8(dio_o);
      chk({7'h0, dio_oe}, 8'h01);
    end
  endtask

  // g: whether the code must start a motion on unit u
  task cmd(input [3:0] c, input g);
    begin
      @(posedge core_clk);
      cmd_wr <= 1'b1;
      dio_i <= rev8({4'h0, c});
      @(posedge core_clk);
      cmd_wr <= 1'b0;
      dio_i <= ~dio_i;
      #1;
      if (g) chk({mot_op, offline_req, mot_go, mot_unit}, {c, c == 4'he, 1'b1, u});
      else chk({7'h0, mot_go}, 8'h00);
    end
  endtask

  task endb(input [7:0] b);
    begin
      @(posedge core_clk);
      end_wr <= 1'b1;
      dio_i <= rev8(b);
      @(posedge core_clk);
      end_wr <= 1'b0;
      dio_i <= ~dio_i;
    end
  endtask

  // polls the interface busy bit, bounded
  task wait_idle;
    begin
      v = 8'h80;
      for (i = 0; i < 20 && v[7]; i = i + 1) rd(2'h2);
      chk({7'h0, v[7]}, 8'h00);
    end
  endtask

  task t_events;
    begin
      @(posedge core_clk);
      pwr <= 1'b1;
      terr <= 1'b1;
      run <= 1'b1;
      onl <= 4'hf;
      @(posedge core_clk);
      pwr <= 1'b0;
      terr <= 1'b0;
      run <= 1'b0;
      rd(2'h3);
      chk(v & 8'hf4, 8'h74);
      rd(2'h2);
      chk(v & 8'h18, 8'h18);
      $display("events test done");
    end
  endtask

  task t_select;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        u = i;
        cmd(u + 4'h1, 1'b0);
        rd(2'h2);
        chk(v & 8'h06, {5'h0, u[0], u[1], 1'b0});
      end
      $display("select test done");
    end
  endtask

  task t_motion;
    reg [3:0] c;
    begin
      for (c = 4'h5; c != 4'h0; c = c + 4'h1) begin
        cmd(c, 1'b1);
        wait_idle;
        rd(2'h0);
        chk(v, 8'h00);
      end
      $display("motion test done");
    end
  endtask

  task t_jump;
    begin
      u = 2'h1;
      cmd(4'h2, 1'b0);
      ok = 1'b0;
      cmd(4'h8, 1'b1);
      wait_idle;
      ok = 1'b1;
      u = 2'h0;
      cmd(4'h1, 1'b0);
      endb(8'h08);
      u = 2'h1;
      cmd(4'h2, 1'b0);
      rd(2'h0);
      chk(v, 8'h01);
      endb(8'h08);
      rd(2'h0);
      chk(v, 8'h00);
      $display("jump test done");
    end
  endtask

  task t_poll;
    begin
      endb(8'h20);
      cmd(4'h8, 1'b1);
      wait_idle;
      chk({4'h0, pp_resp}, 8'h0a);
      endb(8'h80);
      repeat (2) @(posedge core_clk);
      #1 chk({4'h0, pp_resp}, 8'h08);
      endb(8'h40);
      @(posedge core_clk);
      #1 chk({4'h0, poll_off}, 8'h02);
      cmd(4'h8, 1'b1);
      wait_idle;
      @(posedge core_clk);
      rb <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1 chk({4'h0, pp_resp}, 8'h08);
      @(posedge core_clk);
      rb <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 chk({4'h0, pp_resp}, 8'h0a);
      $display("poll test done");
    end
  endtask

  task t_reject;
    begin
      @(posedge core_clk);
      ldp <= 4'hf;
      tend <= 4'hf;
      cmd(4'h0, 1'b0);
      rd(2'h1);
      chk(v & 8'h96, 8'h96);
      rd(2'h0);
      chk(v, 8'h02);
      prot <= 4'hf;
      rew <= 4'hf;
      busy <= 4'hf;
      cmd(4'h5, 1'b0);
      rd(2'h1);
      chk(v & 8'h30, 8'h30);
      rd(2'h2);
      chk(v & 8'h60, 8'h60);
      $display("reject test done");
    end
  endtask

  // mid-run reset: no false on-line events, selection back to unit 0
  task t_reset;
    begin
      @(posedge core_clk);
      arst_n <= 1'b0;
      @(posedge core_clk);
      arst_n <= 1'b1;
      #1 chk({pp_resp, poll_off}, 8'h00);
      rd(2'h3);
      chk(v & 8'hf0, 8'h00);
      rd(2'h2);
      chk(v & 8'h06, 8'h00);
      $display("reset test done");
    end
  endtask

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // hang guard; whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      mismatches = mismatches + 1;
      $display("BAD %0t timeout", $time);
      end_of_test;
    end
  end

  initial begin
    arst_n = 1'b0; cmd_wr = 1'b0; end_wr = 1'b0; stat_rd = 1'b0; stat_sel = 2'h0;
    dio_i = 8'h00; ok = 1'b1; pwr = 1'b0; terr = 1'b0; u = 2'h0; onl = 4'h1;
    ldp = 4'h0; tend = 4'h0; prot = 4'h0; rew = 4'h0; busy = 4'h0; rb = 1'b0; run = 1'b0;
    mismatches = 0; checks_done = 0; cyc = 0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    t_events;
    t_select;
    t_motion;
    t_jump;
    t_poll;
    t_reject;
    t_reset;
    end_of_test;
  end
endmodule

bind tcs_ctrl tcs_ctrl_sva #(.NUNITS(NUNITS)) tcs_ctrl_sva_inst (.*);
